/* pkg/usf_pkg.sv */
// Contract
// - Each of sixteen restarting bits reads set while the unit of that number restarts.
// - One fatal duplicate bit is set on a shared bus-unit number, a shared special-unit number or a twice-used basic word.
// - A summary special-unit error bit is set on a duplicated number or a failed transfer, and the unit number goes to an error word.
// - Sixteen duplication bits mark each special-unit number used twice, only while the fatal duplicate bit is set.
// - Sixteen per-unit error bits are set on a duplicated number or failed transfer of that unit, bit index equal to unit number.
// - A set refresh-disable bit stops data refresh of that unit, except for units on remote racks.
// - The master supports eight or four I/O points per node.
// - In eight-point mode node numbers 0 to 1, 3 or 7 are accepted by word allocation.
// - In four-point mode node numbers 0 to 3, 7 or 15 are accepted by word allocation.
// - Capacity is 32, 64 or 128 points split evenly; lower-end hosts allow only 32 or 64.
package usf_pkg;
  localparam int UNITS  = 16;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;

  // Register word indices
  localparam logic [ADDR_W-1:0] OFF_RESTARTING = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_FATAL      = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_NONFATAL   = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_DUP        = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_UNIT_ERR   = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_ERR_UNIT   = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_RESTART    = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_REFRESH    = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_NODE_CFG   = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT   = 4'h9;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK   = 4'hA;

  // Field positions
  localparam int FATAL_DUP_BIT   = 13;
  localparam int NONFATAL_SU_BIT = 6;
  localparam int CFG_FOUR_BIT    = 0;
  localparam int CFG_ALLOC_LSB   = 1;
  localparam int IRQ_W           = 4;
  localparam int IRQ_DUP         = 0;
  localparam int IRQ_XFER        = 1;
  localparam int IRQ_RESTART_END = 2;
  localparam int IRQ_NODE_RANGE  = 3;

  // Word allocation codes
  localparam logic [1:0] ALLOC_2W = 2'h0;
  localparam logic [1:0] ALLOC_4W = 2'h1;
  localparam logic [1:0] ALLOC_8W = 2'h2;

  // Highest node numbers
  localparam logic [3:0] MAX_NODE_1  = 4'h1;
  localparam logic [3:0] MAX_NODE_3  = 4'h3;
  localparam logic [3:0] MAX_NODE_7  = 4'h7;
  localparam logic [3:0] MAX_NODE_15 = 4'hF;

  // Reset values
  localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
  localparam logic [IRQ_W-1:0]  RST_IRQ  = 4'h0;
  localparam logic [2:0]        RST_CFG  = 3'h0;

  typedef struct packed {
    logic [UNITS-1:0] init_done;   // Unit finished initialisation
    logic [UNITS-1:0] special_dup; // Unit number seen on more than one unit
    logic [UNITS-1:0] remote_rack; // Unit sits on a remote rack
    logic             bus_dup;     // Bus units share a number
    logic             basic_dup;   // Basic word allocated twice
    logic             xfer_err;    // Transfer failure pulse
    logic [3:0]       xfer_unit;   // Unit of the failed transfer
  } unit_events_t;

  typedef struct packed {
    logic       valid;
    logic       is_output;
    logic [3:0] node;
  } node_query_t;
endpackage

/* verilog/unit_supervision_flags.sv */
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module unit_supervision_flags (
  input  wire logic                       mclk,
  input  wire logic                       resetn,
  input  wire logic [usf_pkg::ADDR_W-1:0] addr,
  input  wire logic [usf_pkg::DATA_W-1:0] wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic      [usf_pkg::DATA_W-1:0] rdata,
  input  usf_pkg::unit_events_t           unit_ev,
  input  usf_pkg::node_query_t            node_q,
  input  wire logic                       low_end_host,
  output logic      [usf_pkg::UNITS-1:0]  restarting,
  output logic      [usf_pkg::UNITS-1:0]  restart_pulse,
  output logic      [usf_pkg::UNITS-1:0]  refresh_enable,
  output logic                            node_valid,
  output logic                            node_ok,
  output logic                            four_point_mode,
  output logic      [1:0]                 capacity_sel,
  output logic                            irq
);
  import usf_pkg::*;

  // Allocation 3 is undefined, so it falls back to the largest setting;
  // lower-end hosts cannot address 128 points and are held at 64
  function automatic logic [1:0] eff_alloc(input logic [1:0] a,
                                           input logic       low_end);
    logic [1:0] r;
    r = (a > ALLOC_8W) ? ALLOC_8W : a;
    if (low_end && r == ALLOC_8W) begin
      r = ALLOC_4W;
    end
    return r;
  endfunction

  // Highest legal node number for a point width and allocation
  function automatic logic [3:0] max_node(input logic       four_pt,
                                          input logic [1:0] a);
    logic [3:0] r;
    case (a)
      ALLOC_2W: r = four_pt ? MAX_NODE_3  : MAX_NODE_1;
      ALLOC_4W: r = four_pt ? MAX_NODE_7  : MAX_NODE_3;
      default:  r = four_pt ? MAX_NODE_15 : MAX_NODE_7;
    endcase
    return r;
  endfunction

  logic [UNITS-1:0]  restarting_q, restarting_d;
  logic [UNITS-1:0]  restart_bits_q, restart_bits_d;
  logic [UNITS-1:0]  restart_pulse_q, restart_pulse_d;
  logic [UNITS-1:0]  refresh_dis_q, refresh_dis_d;
  logic [UNITS-1:0]  refresh_en_q, refresh_en_d;
  logic [UNITS-1:0]  dup_q, dup_d;
  logic [UNITS-1:0]  unit_err_q, unit_err_d;
  logic              fatal_q, fatal_d;
  logic [3:0]        err_unit_q, err_unit_d;
  logic [2:0]        cfg_q, cfg_d;
  logic [IRQ_W-1:0]  irq_stat_q, irq_stat_d;
  logic [IRQ_W-1:0]  irq_mask_q, irq_mask_d;
  logic              irq_q, irq_d;
  logic              node_valid_q, node_valid_d;
  logic              node_ok_q, node_ok_d;
  logic [1:0]        cap_q, cap_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;

  logic [UNITS-1:0]  restart_start;
  logic [UNITS-1:0]  restart_end;
  logic [UNITS-1:0]  xfer_onehot;
  logic [IRQ_W-1:0]  irq_set;
  logic              wr_restart;

  // Control and status next-state
  always_comb begin
    wr_restart     = wr && (addr == OFF_RESTART);
    restart_bits_d = wr_restart ? wdata : restart_bits_q;
    // Restart begins on the clearing write of a bit that was set
    restart_start  = restart_bits_q & ~restart_bits_d;
    // Start wins over a stale done from the previous cycle
    restart_end    = restarting_q & unit_ev.init_done & ~restart_start;
    restarting_d   = (restarting_q & ~restart_end) | restart_start;
    restart_pulse_d = restart_start;

    refresh_dis_d = (wr && addr == OFF_REFRESH) ? wdata : refresh_dis_q;
    // Remote-rack units keep refreshing whatever the disable bit says
    refresh_en_d  = ~refresh_dis_q | unit_ev.remote_rack;

    fatal_d = unit_ev.bus_dup | unit_ev.basic_dup
            | (|unit_ev.special_dup);
    dup_d   = fatal_d ? unit_ev.special_dup : RST_WORD;

    xfer_onehot = RST_WORD;
    if (unit_ev.xfer_err) begin
      xfer_onehot[unit_ev.xfer_unit] = 1'b1;
    end
    // Sticky per-unit errors; a new error beats a same-cycle clear
    unit_err_d = unit_err_q;
    if (wr && addr == OFF_UNIT_ERR) begin
      unit_err_d = unit_err_q & ~wdata;
    end
    unit_err_d = unit_err_d | unit_ev.special_dup | xfer_onehot;

    // Transfer failure reports its own unit; else lowest duplicate
    err_unit_d = err_unit_q;
    if (unit_ev.xfer_err) begin
      err_unit_d = unit_ev.xfer_unit;
    end else begin
      for (int i = UNITS - 1; i >= 0; i--) begin
        if (unit_ev.special_dup[i]) begin
          err_unit_d = 4'(i);
        end
      end
    end

    cfg_d = (wr && addr == OFF_NODE_CFG) ? wdata[2:0] : cfg_q;
    cap_d = eff_alloc(cfg_q[CFG_ALLOC_LSB +: 2], low_end_host);

    // Node range check; inputs and outputs share the same limit
    node_valid_d = node_q.valid;
    node_ok_d    = node_q.valid &&
                   (node_q.node <= max_node(cfg_q[CFG_FOUR_BIT],
                                            cap_q));

    irq_set = RST_IRQ;
    irq_set[IRQ_DUP]         = fatal_d && !fatal_q;
    irq_set[IRQ_XFER]        = unit_ev.xfer_err;
    irq_set[IRQ_RESTART_END] = |restart_end;
    irq_set[IRQ_NODE_RANGE]  = node_q.valid && !node_ok_d;
    irq_stat_d = irq_stat_q;
    if (wr && addr == OFF_IRQ_STAT) begin
      irq_stat_d = irq_stat_q & ~wdata[IRQ_W-1:0];
    end
    irq_stat_d = irq_stat_d | irq_set;
    irq_mask_d = (wr && addr == OFF_IRQ_MASK) ? wdata[IRQ_W-1:0]
                                              : irq_mask_q;
    irq_d = |(irq_stat_d & irq_mask_d);
  end

  // Control and status registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      restarting_q    <= RST_WORD;
      restart_bits_q  <= RST_WORD;
      restart_pulse_q <= RST_WORD;
      refresh_dis_q   <= RST_WORD;
      refresh_en_q    <= RST_WORD;
      dup_q           <= RST_WORD;
      unit_err_q      <= RST_WORD;
      fatal_q         <= 1'b0;
      err_unit_q      <= 4'h0;
      cfg_q           <= RST_CFG;
      cap_q           <= ALLOC_2W;
      node_valid_q    <= 1'b0;
      node_ok_q       <= 1'b0;
      irq_stat_q      <= RST_IRQ;
      irq_mask_q      <= RST_IRQ;
      irq_q           <= 1'b0;
    end else begin
      restarting_q    <= restarting_d;
      restart_bits_q  <= restart_bits_d;
      restart_pulse_q <= restart_pulse_d;
      refresh_dis_q   <= refresh_dis_d;
      refresh_en_q    <= refresh_en_d;
      dup_q           <= dup_d;
      unit_err_q      <= unit_err_d;
      fatal_q         <= fatal_d;
      err_unit_q      <= err_unit_d;
      cfg_q           <= cfg_d;
      cap_q           <= cap_d;
      node_valid_q    <= node_valid_d;
      node_ok_q       <= node_ok_d;
      irq_stat_q      <= irq_stat_d;
      irq_mask_q      <= irq_mask_d;
      irq_q           <= irq_d;
    end
  end

  // Read mux; data valid only in the cycle after the strobe
  always_comb begin
    rdata_d = RST_WORD;
    if (rd) begin
      case (addr)
        OFF_RESTARTING: rdata_d = restarting_q;
        OFF_FATAL:      rdata_d[FATAL_DUP_BIT] = fatal_q;
        OFF_NONFATAL:   rdata_d[NONFATAL_SU_BIT] = |unit_err_q;
        OFF_DUP:        rdata_d = dup_q;
        OFF_UNIT_ERR:   rdata_d = unit_err_q;
        OFF_ERR_UNIT:   rdata_d[3:0] = err_unit_q;
        OFF_RESTART:    rdata_d = restart_bits_q;
        OFF_REFRESH:    rdata_d = refresh_dis_q;
        OFF_NODE_CFG:   rdata_d = {11'h000, cap_q, cfg_q};
        OFF_IRQ_STAT:   rdata_d[IRQ_W-1:0] = irq_stat_q;
        OFF_IRQ_MASK:   rdata_d[IRQ_W-1:0] = irq_mask_q;
        default:        rdata_d = RST_WORD;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= RST_WORD;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata           = rdata_q;
  assign restarting      = restarting_q;
  assign restart_pulse   = restart_pulse_q;
  assign refresh_enable  = refresh_en_q;
  assign node_valid      = node_valid_q;
  assign node_ok         = node_ok_q;
  assign four_point_mode = cfg_q[CFG_FOUR_BIT];
  assign capacity_sel    = cap_q;
  assign irq             = irq_q;

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  // Clearing write of a set restart bit raises restarting next cycle
  chk_restart_start: assert property (
    (wr && addr == OFF_RESTART) ##0 (restart_bits_q[0] && !wdata[0])
    |=> restarting[0] && restart_pulse[0])
    else $error("restart did not start on set-then-clear");

  // Restarting holds until the unit reports init done
  chk_restart_hold: assert property (
    restarting[0] && !unit_ev.init_done[0] |=> restarting[0])
    else $error("restarting dropped before init done");

  // Setting a restart bit alone never starts a restart
  chk_restart_setonly: assert property (
    !restarting[0] && !restart_bits_q[0] |=> !restart_pulse[0])
    else $error("restart started without a clear");

  // A bus or basic duplicate sets the fatal bit one cycle later
  chk_fatal_dup: assert property (
    unit_ev.basic_dup || unit_ev.bus_dup |=> fatal_q)
    else $error("fatal duplicate bit missing");

  // Duplication flags only live under the fatal bit
  chk_dup_gated: assert property (
    (|dup_q) |-> fatal_q)
    else $error("duplication flag without fatal bit");

  // Transfer error records its unit and sets its flag
  chk_xfer_record: assert property (
    unit_ev.xfer_err |=> err_unit_q == $past(unit_ev.xfer_unit)
    && unit_err_q[$past(unit_ev.xfer_unit)])
    else $error("transfer error not recorded");

  // Per-unit error bit stays set with no clearing write
  chk_unit_err_sticky: assert property (
    unit_err_q[2] && !(wr && addr == OFF_UNIT_ERR) |=> unit_err_q[2])
    else $error("unit error bit lost");

  // Refresh follows the disable bit unless the unit is remote
  chk_refresh_dis: assert property (
    refresh_dis_q[1] && !unit_ev.remote_rack[1] |=> !refresh_enable[1])
    else $error("refresh not suppressed");

  // Eight-point, two-word mode refuses node two
  chk_node_eight: assert property (
    node_q.valid && !cfg_q[CFG_FOUR_BIT] && cap_q == ALLOC_2W
    && node_q.node == 4'h2 |=> node_valid && !node_ok)
    else $error("node range not enforced");

  // Four-point, eight-word mode accepts node fifteen
  chk_node_four: assert property (
    node_q.valid && cfg_q[CFG_FOUR_BIT] && cap_q == ALLOC_8W
    && node_q.node == 4'hF |=> node_ok)
    else $error("four-point node refused");

  // Lower-end host never gets the 128-point setting
  chk_cap_low_end: assert property (
    low_end_host |=> capacity_sel != ALLOC_8W)
    else $error("capacity too large for host");

  // Restart order to a unit lasts a single cycle
  chk_pulse_single: assert property (
    restart_pulse[0] |=> !restart_pulse[0])
    else $error("restart pulse longer than one cycle");

  // Restarting word reads back what the flags held at the strobe
  chk_restarting_read: assert property (
    rd && addr == OFF_RESTARTING |=> rdata == $past(restarting))
    else $error("restarting word misread");

  // Special-unit duplicates raise fatal and mirror into the flags
  chk_dup_mirror: assert property (
    (|unit_ev.special_dup) |=> fatal_q
    && dup_q == $past(unit_ev.special_dup))
    else $error("duplication flags do not follow");

  // Summary bit reads set while any unit error is held
  chk_summary_read: assert property (
    rd && addr == OFF_NONFATAL && (|unit_err_q)
    |=> rdata[NONFATAL_SU_BIT])
    else $error("summary error bit missing");

  // A remote-rack unit keeps refreshing whatever its disable bit says
  chk_refresh_remote: assert property (
    unit_ev.remote_rack[1] |=> refresh_enable[1])
    else $error("remote unit refresh stopped");
endmodule

/* sim/unit_model.sv */
`timescale 1ns/1ps
module unit_model (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        slow,
  input  wire logic [15:0] restart_pulse,
  output logic      [15:0] init_done
);
  logic [4:0] cnt_q [16];

  // Each unit counts out its own initialisation; done shows for one cycle
  // only, so a stale level can never end a later restart early
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      init_done <= 16'h0000;
      for (int i = 0; i < 16; i++) cnt_q[i] <= 5'h00;
    end else begin
      for (int i = 0; i < 16; i++) begin
        init_done[i] <= (cnt_q[i] == 5'h01);
        if (restart_pulse[i]) cnt_q[i] <= slow ? 5'h14 : 5'h02;
        else if (cnt_q[i] != 5'h00) cnt_q[i] <= cnt_q[i] - 5'h01;
      end
    end
  end
endmodule

/* sim/unit_supervision_flags_test.sv */
`timescale 1ns/1ps
module unit_supervision_flags_test;
  import usf_pkg::*;
  logic              mclk = 1'b0;
  logic              resetn = 1'b0;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [DATA_W-1:0] wdata = 16'h0000;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              low_end = 1'b0;
  logic              slow = 1'b0;
  unit_events_t      ev = '0;
  unit_events_t      ev_in;
  node_query_t       nq = '0;
  logic [DATA_W-1:0] rdata, m, v;
  logic [UNITS-1:0]  restarting, rpulse, refresh_en, init_done;
  logic              node_valid, node_ok, four, irq;
  logic [1:0]        cap, e;
  int                error_cnt = 0;
  int                num_checks = 0;
  int                u;

  always #50 mclk = ~mclk;

  // Completion flags come from the unit model, all other events from here
  always_comb begin
    ev_in = ev;
    ev_in.init_done = init_done;
  end

  unit_supervision_flags unit_supervision_flags_inst (
    .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .unit_ev(ev_in), .node_q(nq),
    .low_end_host(low_end), .restarting(restarting), .restart_pulse(rpulse),
    .refresh_enable(refresh_en), .node_valid(node_valid), .node_ok(node_ok),
    .four_point_mode(four), .capacity_sel(cap), .irq(irq));

  unit_model unit_model_inst (
    .mclk(mclk), .resetn(resetn), .slow(slow), .restart_pulse(rpulse),
    .init_done(init_done));

  // Allocation 3 counts as 8 words; a low-end host is held to 4 words
  function automatic logic [1:0] eff(input logic [1:0] a, input logic le);
    eff = (a == 2'h3) ? 2'h2 : a;
    if (le && eff == 2'h2) eff = 2'h1;
  endfunction

  function automatic logic [3:0] lim(input logic f, input logic [1:0] x);
    if (f) lim = (x == 2'h0) ? 4'h3 : (x == 2'h1) ? 4'h7 : 4'hF;
    else lim = (x == 2'h0) ? 4'h1 : (x == 2'h1) ? 4'h3 : 4'h7;
  endfunction

  function automatic logic [3:0] low1(input logic [15:0] x);
    low1 = 4'h0;
    for (int i = 15; i >= 0; i--) if (x[i]) low1 = 4'(i);
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] x,
                     input logic [15:0] g);
    num_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic creg(input string n, input logic [3:0] a,
                      input logic [15:0] x);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(n, x, rdata);
  endtask

  task automatic wait_idle(input int k);
    int n;
    n = 0;
    while (restarting[k] !== 1'b0 && n < 60) begin
      @(posedge mclk);
      #1 n++;
    end
    if (n == 60) begin
      error_cnt++;
      $display("MISMATCH restart wait expected end seen hang");
      end_of_test();
    end
  endtask

  initial begin
    u = $urandom(58);
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    // Read-only and unmapped writes must leave every word at zero
    wreg(OFF_RESTARTING, 16'hFFFF);
    wreg(4'hC, 16'hFFFF);
    for (int a = 0; a < 16; a++) creg("reset word", 4'(a), 16'h0000);
    $display("test reset done");
    // Prompt then slow unit; only the clear edge of the bit starts it
    wreg(OFF_IRQ_MASK, 16'h0004);
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      u = s[0] ? $urandom_range(15) : 0;  // Unit 0 first as a corner
      wreg(OFF_RESTART, 16'h0001 << u);
      #1 chk("restarting early", 16'h0000, restarting);
      wreg(OFF_RESTART, 16'h0000);
      #1 chk("restarting", 16'h0001 << u, restarting);
      chk("restart pulse", 16'h0001 << u, rpulse);
      wait_idle(u);
      @(posedge mclk);
      #1 chk("irq raised", 16'h0001, 16'(irq));
      creg("irq status", OFF_IRQ_STAT, 16'h0004);
      wreg(OFF_IRQ_STAT, 16'h0004);
      @(posedge mclk);
      #1 chk("irq cleared", 16'h0000, 16'(irq));
    end
    $display("test restart done");
    m = (16'($urandom) & 16'hFFF0) | 16'h0104;
    @(posedge mclk);
    ev.special_dup <= m;
    repeat (2) @(posedge mclk);
    creg("fatal", OFF_FATAL, 16'h2000);
    creg("dup flags", OFF_DUP, m);
    creg("nonfatal", OFF_NONFATAL, 16'h0040);
    creg("unit errors", OFF_UNIT_ERR, m);
    creg("error unit", OFF_ERR_UNIT, 16'(low1(m)));
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk);
      ev.special_dup <= 16'h0000;
      ev.bus_dup <= (k == 0);
      ev.basic_dup <= (k == 1);
      repeat (2) @(posedge mclk);
      creg("fatal other", OFF_FATAL, (k < 2) ? 16'h2000 : 16'h0000);
      creg("dup idle", OFF_DUP, 16'h0000);
    end
    creg("sticky errors", OFF_UNIT_ERR, m);
    wreg(OFF_UNIT_ERR, 16'hFFFF);
    creg("errors cleared", OFF_UNIT_ERR, 16'h0000);
    $display("test duplicate done");
    u = $urandom_range(15);
    @(posedge mclk);
    ev.xfer_err <= 1'b1;
    ev.xfer_unit <= 4'(u);
    @(posedge mclk);
    ev.xfer_err <= 1'b0;
    creg("xfer error", OFF_UNIT_ERR, 16'h0001 << u);
    creg("xfer unit", OFF_ERR_UNIT, 16'(u));
    creg("xfer summary", OFF_NONFATAL, 16'h0040);
    creg("irq sources", OFF_IRQ_STAT, 16'h0003);
    $display("test transfer done");
    for (int k = 0; k < 4; k++) begin
      m = 16'($urandom);
      v = 16'($urandom);
      wreg(OFF_REFRESH, m);
      ev.remote_rack <= v;
      repeat (2) @(posedge mclk);
      #1 chk("refresh", ~m | v, refresh_en);
      creg("refresh bits", OFF_REFRESH, m);
    end
    $display("test refresh done");
    // Every mode, allocation and host kind, every node number
    for (int c = 0; c < 16; c++) begin
      wreg(OFF_NODE_CFG, 16'(c[2:0]));
      low_end <= c[3];
      repeat (2) @(posedge mclk);
      e = eff(c[2:1], c[3]);
      #1 chk("capacity", 16'(e), 16'(cap));
      chk("four point", 16'(c[0]), 16'(four));
      creg("node cfg", OFF_NODE_CFG, 16'({e, c[2:0]}));
      for (int n = 0; n < 16; n++) begin
        @(posedge mclk);
        nq <= '{1'b1, 1'($urandom), 4'(n)};
        @(posedge mclk);
        nq.valid <= 1'b0;
        #1 chk("node", 16'({1'b1, 4'(n) <= lim(c[0], e)}),
               16'({node_valid, node_ok}));
      end
    end
    $display("test node range done");
    end_of_test();
  end
endmodule
